/* rtl/adcrt_top.sv */
// converter reference, clock and trigger configuration with APB register access
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcrt_params.svh"

module adcrt_top #(
   parameter int NUM_SRC = 18,
   parameter int ADDR_W  = 8
) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic [NUM_SRC-1:0] trigger_sources,
   input  wire logic [9:0]         conversion_result_in,
   output logic                    neg_ref_to_ground,
   output logic                    neg_ref_to_pin,
   output logic                    pos_ref_to_supply,
   output logic                    pos_ref_to_pin,
   output logic                    pos_ref_to_fixed,
   output logic                    channel_mux_connect,
   output logic      [2:0]         conversion_clock_select,
   output logic                    conversion_start,
   output logic                    conversion_busy
);
   import adcrt_pkg::*;

   generate
      // the decode slices the low byte of the address, so at least eight bits are needed
      if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
         $error("adcrt_top: ADDR_W out of range");
      end
   endgenerate

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] adcrt_idx(input logic [ADDR_W-1:0] a);
      adcrt_idx = a[7:0];
   endfunction

   function automatic logic adcrt_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = adcrt_idx(a);
      adcrt_hit = (a[ADDR_W-1:0] == ADDR_W'(i)) &&
                  (i == `ADCRT_OFS_CTRL0 || i == `ADCRT_OFS_CTRL1 ||
                   i == `ADCRT_OFS_TRIG || i == `ADCRT_OFS_RES_HI ||
                   i == `ADCRT_OFS_RES_LO);
   endfunction

   function automatic logic [31:0] adcrt_read(input logic [ADDR_W-1:0] a,
                                              input adcrt_state_t  r);
      logic [7:0] v;
      v = 8'h00;
      unique case (adcrt_idx(a))
         `ADCRT_OFS_CTRL0:  v = {6'h00, r.go, r.enable};
         `ADCRT_OFS_CTRL1:  v = {r.justify, r.clk_sel, 1'b0, r.nref, r.pref};
         `ADCRT_OFS_TRIG:   v = {3'h0, r.trig};
         `ADCRT_OFS_RES_HI: v = r.justify ? {6'h00, r.result[9:8]} : r.result[9:2];
         `ADCRT_OFS_RES_LO: v = r.justify ? r.result[7:0] : {r.result[1:0], 6'h00};
         default:           v = 8'h00;
      endcase
      if (a[ADDR_W-1:0] != ADDR_W'(adcrt_idx(a))) begin
         v = 8'h00;
      end
      adcrt_read = {24'h000000, v};
   endfunction

   adcrt_state_t s;
   adcrt_state_t n;
   logic         trig_pulse;
   logic         acc;
   logic         wr;
   logic         sw_go_set;
   logic         sw_go_clr;
   logic         start;

   // ----------------------------------------------------------------
   // trigger source selection
   // ----------------------------------------------------------------
   adcrt_trig_sel #(
      .NUM_SRC (NUM_SRC)
   ) u_trig (
      .clock      (clock),
      .rst_n      (rst_n),
      .ce         (ce),
      .sel        (s.trig),
      .sources    (trigger_sources),
      .trig_pulse (trig_pulse)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n            = s;
      n.pready     = 1'b0;
      n.pslverr    = 1'b0;
      n.conv_start = 1'b0;
      acc          = psel && penable && s.pready;
      wr           = acc && pwrite;
      sw_go_set    = 1'b0;
      sw_go_clr    = 1'b0;
      start        = 1'b0;
      // setup phase: answer is prepared so pready comes from a flop
      if (psel && !penable && !s.pready) begin
         n.pready  = 1'b1;
         n.pslverr = !adcrt_hit(paddr);
         n.prdata  = pwrite ? 32'h00000000 : adcrt_read(paddr, s);
      end
      // writes land only at the completing access edge
      if (wr && adcrt_hit(paddr)) begin
         unique case (adcrt_idx(paddr))
            `ADCRT_OFS_CTRL0: begin
               n.enable  = pwdata[`ADCRT_CTRL0_ENABLE];
               sw_go_set = pwdata[`ADCRT_CTRL0_GO];
               sw_go_clr = !pwdata[`ADCRT_CTRL0_GO];
            end
            `ADCRT_OFS_CTRL1: begin
               n.justify = pwdata[`ADCRT_CTRL1_JUSTIFY];
               n.clk_sel = pwdata[`ADCRT_CTRL1_CLK_HI:`ADCRT_CTRL1_CLK_LO];
               n.nref    = pwdata[`ADCRT_CTRL1_NREF];
               n.pref    = pwdata[`ADCRT_CTRL1_PREF_HI:`ADCRT_CTRL1_PREF_LO];
            end
            `ADCRT_OFS_TRIG: begin
               n.trig = pwdata[`ADCRT_TRIG_HI:0];
            end
            default: begin
               n.trig = n.trig;
            end
         endcase
      end
      // software go or selected peripheral flag edge starts a conversion
      start = n.enable && (sw_go_set ||
              (trig_pulse && s.trig != `ADCRT_TRIG_NONE));
      unique case (s.st)
         ADCRT_IDLE: begin
            if (start) begin
               n.st         = ADCRT_CONV;
               n.go         = 1'b1;
               n.cnt        = `ADCRT_CONV_CYCLES - 8'h01;
               n.conv_start = 1'b1;
            end else begin
               n.go = 1'b0;
            end
         end
         ADCRT_CONV: begin
            if (!n.enable || sw_go_clr) begin
               // disable or software clear aborts; result is kept
               n.st = ADCRT_IDLE;
               n.go = 1'b0;
            end else if (s.cnt == 8'h00) begin
               n.result = conversion_result_in;
               if (start) begin
                  // a new start in the completion cycle wins over the clear
                  n.cnt        = `ADCRT_CONV_CYCLES - 8'h01;
                  n.conv_start = 1'b1;
               end else begin
                  n.st = ADCRT_IDLE;
                  n.go = 1'b0;
               end
            end else begin
               n.cnt = s.cnt - 8'h01;
            end
         end
      endcase
      // mux connections follow the registered fields, all open when disabled
      n.neg_gnd     = n.enable && !n.nref;
      n.neg_pin     = n.enable && n.nref;
      n.pos_supply  = n.enable && n.pref == `ADCRT_PREF_SUPPLY;
      n.pos_pin     = n.enable && n.pref == `ADCRT_PREF_PIN;
      n.pos_fixed   = n.enable && n.pref == `ADCRT_PREF_FIXED;
      n.mux_connect = n.enable;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s         <= '0;
         s.st      <= ADCRT_IDLE;
         s.clk_sel <= `ADCRT_RST_CLK_SEL;
         s.pref    <= `ADCRT_RST_PREF;
         s.trig    <= `ADCRT_RST_TRIG;
      end else if (ce) begin
         s <= n;
      end
   end

   // outputs straight from the state flops
   assign prdata                  = s.prdata;
   assign pready                  = s.pready;
   assign pslverr                 = s.pslverr;
   assign neg_ref_to_ground       = s.neg_gnd;
   assign neg_ref_to_pin          = s.neg_pin;
   assign pos_ref_to_supply       = s.pos_supply;
   assign pos_ref_to_pin          = s.pos_pin;
   assign pos_ref_to_fixed        = s.pos_fixed;
   assign channel_mux_connect     = s.mux_connect;
   assign conversion_clock_select = s.clk_sel;
   assign conversion_start        = s.conv_start;
   assign conversion_busy         = s.go;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock iff ce); endclocking
   default disable iff (!rst_n);

   property p_nref;
      s.enable |-> (neg_ref_to_pin == s.nref) && (neg_ref_to_ground == !s.nref);
   endproperty
   a_nref: assert property (p_nref) else $error("negative reference route wrong");

   property p_off;
      !s.enable |-> !(neg_ref_to_ground || neg_ref_to_pin || pos_ref_to_supply ||
                      pos_ref_to_pin || pos_ref_to_fixed || channel_mux_connect);
   endproperty
   a_off: assert property (p_off) else $error("mux connected while disabled");

   property p_pref;
      s.enable |-> (pos_ref_to_pin == (s.pref == `ADCRT_PREF_PIN)) &&
                   (pos_ref_to_fixed == (s.pref == `ADCRT_PREF_FIXED)) &&
                   (pos_ref_to_supply == (s.pref == `ADCRT_PREF_SUPPLY));
   endproperty
   a_pref: assert property (p_pref) else $error("positive reference route wrong");

   property p_bit3;
      (acc && !pwrite && adcrt_idx(paddr) == `ADCRT_OFS_CTRL1) |-> !prdata[3];
   endproperty
   a_bit3: assert property (p_bit3) else $error("control bit 3 read nonzero");

   property p_trig_start;
      (trig_pulse && s.enable && s.st == ADCRT_IDLE && s.trig != `ADCRT_TRIG_NONE && !wr)
         |=> conversion_start && conversion_busy;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

   property p_done;
      (conversion_start && !psel) ##1 (!psel && s.enable) [*8] |->
         ##[3:5] !conversion_busy;
   endproperty
   a_done: assert property (p_done) else $error("go bit not cleared after conversion");

   property p_left;
      (acc && !pwrite && adcrt_idx(paddr) == `ADCRT_OFS_RES_HI && !$past(s.justify))
         |-> prdata[7:0] == $past(s.result[9:2]);
   endproperty
   a_left: assert property (p_left) else $error("left justified high byte wrong");

   property p_trig_hi;
      (acc && !pwrite && adcrt_idx(paddr) == `ADCRT_OFS_TRIG) |-> prdata[7:5] == 3'h0;
   endproperty
   a_trig_hi: assert property (p_trig_hi) else $error("trigger upper bits nonzero");

   c_trig_conv: cover property (trig_pulse && s.trig != `ADCRT_TRIG_NONE ##1 conversion_start);
   c_sw_conv:   cover property (conversion_start ##[1:20] !conversion_busy);
   c_bad_addr:  cover property (acc && pslverr);

endmodule

`default_nettype wire

/* pkg/adcrt_params.svh */
// register map, field positions, reset values and timing counts of the converter control block
`ifndef ADCRT_PARAMS_SVH
`define ADCRT_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADCRT_OFS_CTRL0   8'h00
`define ADCRT_OFS_CTRL1   8'h04
`define ADCRT_OFS_TRIG    8'h08
`define ADCRT_OFS_RES_HI  8'h0c
`define ADCRT_OFS_RES_LO  8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCRT_CTRL0_ENABLE   0
`define ADCRT_CTRL0_GO       1
`define ADCRT_CTRL1_JUSTIFY  7
`define ADCRT_CTRL1_CLK_HI   6
`define ADCRT_CTRL1_CLK_LO   4
`define ADCRT_CTRL1_NREF     2
`define ADCRT_CTRL1_PREF_HI  1
`define ADCRT_CTRL1_PREF_LO  0
`define ADCRT_TRIG_HI        4

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define ADCRT_RST_CLK_SEL    3'h0
`define ADCRT_RST_PREF       2'h0
`define ADCRT_RST_TRIG       5'h00
`define ADCRT_PREF_SUPPLY    2'h0
`define ADCRT_PREF_RESERVED  2'h1
`define ADCRT_PREF_PIN       2'h2
`define ADCRT_PREF_FIXED     2'h3
`define ADCRT_TRIG_NONE      5'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define ADCRT_CONV_CYCLES    8'h0c

`endif

/* pkg/adcrt_pkg.sv */
// types shared by the converter control block
package adcrt_pkg;

   // conversion sequencer states, one-hot
   typedef enum logic [1:0] {
      ADCRT_IDLE = 2'b01,
      ADCRT_CONV = 2'b10
   } adcrt_state_e_t;

   // whole state of the top module
   typedef struct packed {
      logic           enable;
      logic           go;
      logic           justify;
      logic [2:0]     clk_sel;
      logic           nref;
      logic [1:0]     pref;
      logic [4:0]     trig;
      logic [9:0]     result;
      logic [7:0]     cnt;
      adcrt_state_e_t st;
      logic [31:0]    prdata;
      logic           pready;
      logic           pslverr;
      logic           neg_gnd;
      logic           neg_pin;
      logic           pos_supply;
      logic           pos_pin;
      logic           pos_fixed;
      logic           mux_connect;
      logic           conv_start;
   } adcrt_state_t;

   // whole state of the trigger selector
   typedef struct packed {
      logic prev;
      logic pulse;
   } adcrt_trig_state_t;

endpackage

/* rtl/adcrt_trig_sel.sv */
// trigger source selector with rising-edge detection
`timescale 1ns/1ps
`default_nettype none
`include "adcrt_params.svh"

module adcrt_trig_sel #(
   parameter int NUM_SRC = 18
) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic [4:0]         sel,
   input  wire logic [NUM_SRC-1:0] sources,
   output logic                    trig_pulse
);
   import adcrt_pkg::*;

   // a five-bit select reaches 32 codes at most; code 0 is never a source
   generate
      if (NUM_SRC < 2 || NUM_SRC > 32) begin : g_bad
         $error("adcrt_trig_sel: NUM_SRC out of range");
      end
   endgenerate

   adcrt_trig_state_t s;
   adcrt_trig_state_t n;
   logic              level;

   // pick the selected level; code 0 and codes past the list give no trigger
   always_comb begin
      level = 1'b0;
      if (sel != `ADCRT_TRIG_NONE && 32'(sel) < NUM_SRC) begin
         level = sources[sel];
      end
      n.prev  = level;
      n.pulse = level & ~s.prev;
   end

   // a select change may show one edge if the new source is already high
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign trig_pulse = s.pulse;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_edge_only;
      @(posedge clock iff ce) disable iff (!rst_n)
      trig_pulse |=> !trig_pulse;
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("trigger pulse repeated");

   property p_none_quiet;
      @(posedge clock iff ce) disable iff (!rst_n)
      (sel == `ADCRT_TRIG_NONE) |=> !trig_pulse;
   endproperty
   a_none_quiet: assert property (p_none_quiet) else $error("trigger from code zero");

endmodule

`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the converter reference and trigger configuration block
`timescale 1ns/1ps
`default_nettype none
`include "adcrt_params.svh"

module testbench;
   localparam int NUM_SRC = 18;
   logic               clock;
   logic               rst_n;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [NUM_SRC-1:0] srcs;
   logic [9:0]         res_in;
   logic               n_gnd;
   logic               n_pin;
   logic               p_sup;
   logic               p_pin;
   logic               p_fix;
   logic               mux_on;
   logic [2:0]         clk_sel;
   logic               start;
   logic               busy;
   int                 bad_count;
   int                 checks_done;
   int                 start_cnt;

   // ----------------------------------------------------------------
   // clock, device and pulse monitor
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ce tied high: clock gating is outside this bench's reach
   adcrt_top #(.NUM_SRC(NUM_SRC), .ADDR_W(8)) dut_u (
      .clock(clock), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_sources(srcs),
      .conversion_result_in(res_in), .neg_ref_to_ground(n_gnd), .neg_ref_to_pin(n_pin),
      .pos_ref_to_supply(p_sup), .pos_ref_to_pin(p_pin), .pos_ref_to_fixed(p_fix),
      .channel_mux_connect(mux_on), .conversion_clock_select(clk_sel),
      .conversion_start(start), .conversion_busy(busy));

   // counts start pulses so held levels can be shown not to retrigger
   always @(posedge clock) begin
      if (start === 1'b1) start_cnt++;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; waits on pready, never on a fixed count
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) check(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic        e;
      apb(1'b1, addr, data, d, e);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'b0, addr, 32'h0, d, e);
      check(d, exp);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset state, unimplemented bits and an unmapped address
   task automatic t_regs;
      logic [31:0] d;
      logic        e;
      check({n_gnd, n_pin, p_sup, p_pin, p_fix, mux_on, busy}, 32'h0);
      rd_chk(`ADCRT_OFS_CTRL1, 32'h0);
      wr(`ADCRT_OFS_CTRL1, 32'h0000_00ff);
      rd_chk(`ADCRT_OFS_CTRL1, 32'h0000_00f7);
      check(clk_sel, 32'h7);
      wr(`ADCRT_OFS_TRIG, 32'h0000_00ff);
      rd_chk(`ADCRT_OFS_TRIG, 32'h0000_001f);
      wr(`ADCRT_OFS_TRIG, 32'h0000_00e5);
      rd_chk(`ADCRT_OFS_TRIG, 32'h0000_0005);
      apb(1'b0, 8'h20, 32'h0, d, e);
      check(e, 32'h1);
      check(d, 32'h0);
      wr(`ADCRT_OFS_CTRL1, 32'h0);
   endtask

   // every reference code, with the converter off and on
   task automatic t_refs;
      logic [2:0] v;
      for (int en = 0; en < 2; en++) begin
         wr(`ADCRT_OFS_CTRL0, en);
         for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            wr(`ADCRT_OFS_CTRL1, {29'h0, v});
            cycles(2);
            check({n_gnd, n_pin}, en ? {!v[2], v[2]} : 2'b00);
            check({p_sup, p_pin, p_fix},
                  en ? {v[1:0] == 2'h0, v[1:0] == 2'h2, v[1:0] == 2'h3} : 3'b000);
            check(mux_on, en);
         end
      end
      wr(`ADCRT_OFS_CTRL1, 32'h0);
   endtask

   // software start, self-clearing go bit, left-justified result
   task automatic t_go;
      int n;
      int s0;
      n = 0;
      s0 = start_cnt;
      wr(`ADCRT_OFS_CTRL0, 32'h3);
      repeat (30) begin
         @(posedge clock);
         if (busy === 1'b1) n++;
      end
      check(n, `ADCRT_CONV_CYCLES);
      check(start_cnt - s0, 1);
      rd_chk(`ADCRT_OFS_CTRL0, 32'h1);
      rd_chk(`ADCRT_OFS_RES_HI, {24'h0, res_in[9:2]});
      rd_chk(`ADCRT_OFS_RES_LO, {24'h0, res_in[1:0], 6'h0});
   endtask

   // every trigger code up to NUM_SRC; code zero must stay silent even with all sources high
   task automatic t_trig;
      int n;
      int s0;
      wr(`ADCRT_OFS_CTRL0, 32'h1);
      wr(`ADCRT_OFS_TRIG, `ADCRT_TRIG_NONE);
      s0 = start_cnt;
      srcs <= '1;
      cycles(20);
      check(start_cnt - s0, 0);
      srcs <= '0;
      cycles(2);
      for (int k = 1; k < NUM_SRC; k++) begin
         wr(`ADCRT_OFS_TRIG, k);
         cycles(2);
         s0 = start_cnt;
         srcs[k] <= 1'b1;
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (start !== 1'b1 && n < 10);
         check(n, 3);
         // level left high across and after the whole conversion
         cycles(36);
         check(start_cnt - s0, 1);
         srcs[k] <= 1'b0;
         cycles(2);
      end
      // a code past the last wired source must stay silent as well
      wr(`ADCRT_OFS_TRIG, NUM_SRC);
      s0 = start_cnt;
      srcs <= '1;
      cycles(20);
      check(start_cnt - s0, 0);
      srcs <= '0;
      cycles(2);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      srcs = '0;
      res_in = 10'h2b5;
      bad_count = 0;
      checks_done = 0;
      start_cnt = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_refs();
      t_go();
      t_trig();
      final_report();
   end

   // the full run needs about a thousand cycles; this is far beyond it
   initial begin
      #(8 * 100000);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
